// file: acpc_defs.svh
`ifndef ACPC_DEFS_SVH
`define ACPC_DEFS_SVH
// ==========================================================
// register map, byte addresses on the register bus
`define ACPC_ADDR_CTRL 4'h0
`define ACPC_ADDR_SETUP 4'h4
`define ACPC_ADDR_STATUS 4'h8
// ==========================================================
// control register fields
`define ACPC_CTRL_INTCLK 0
`define ACPC_CTRL_PM_LO 1
`define ACPC_CTRL_PM_HI 2
`define ACPC_CTRL_SOFTWARE_CONVERT_BIT 3
`define ACPC_CTRL_SEL_LSB 4
`define ACPC_CTRL_SEL_MSB 7
// ==========================================================
// setup word fields carried in a serial frame
`define ACPC_SEL_CODE_MSB 15
`define ACPC_SEL_CODE_LSB 11
`define ACPC_SETUP_CODE 5'h10
`define ACPC_REFERENCE_SELECT_BIT 10
`define ACPC_AVERAGING_ENABLE_BIT 9
`define ACPC_NAVG_MSB 8
`define ACPC_NAVG_LSB 7
`define ACPC_SPM_MSB 4
`define ACPC_SPM_LSB 3
`define ACPC_ECHO_BIT 2
`define ACPC_SETUP_RESET 16'h0000
// ==========================================================
// power codes and conversion counts
`define ACPC_PWR_NORMAL 2'h0
`define ACPC_PWR_FULL 2'h1
`define ACPC_PWR_PARTIAL 2'h2
`define ACPC_WARM_CONVS 2'h2
`define ACPC_CONV_NS 160
`define ACPC_CLK_NS 10
`define ACPC_CONV_CYCLES ((`ACPC_CONV_NS + `ACPC_CLK_NS - 1) / `ACPC_CLK_NS)
`endif

// file: acpc_pkg.sv
// ==========================================================
// shared types
package acpc_pkg;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_BURST,
		ST_DOWN
	} acpc_state_t;
endpackage

// file: acpc_ctrl.sv
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "acpc_defs.svh"
// Behaviour
// R1: input select code decodes binary to input
// R2: nonzero static field holds static shutdown
// R3: full shutdown all off, partial keeps bias
// R4: external clock auto mode: off at frame-end
// R5: external clock auto mode: on at cs fall
// R6: internal clock: off after burst completes
// R7: internal clock wake: convert pin or software_convert_bit
// R8: auto power field 00 normal, 01 off, 10 standby
// R9: auto full shutdown powers everything down
// R10: first two conversions after wake invalid
// R11: registers retained through automatic power-down
// R12: auto standby keeps bias, wakes cs fall
// R13: frame code 10000 writes setup register
// R14: bit 10 selects differential reference
// R15: bit 9 enables averaging, internal clock only
// R16: bits 8:7 pick 4, 8, 16 or 32 conversions
// R17: static field bits 4:3, 01 full, 10 partial
// R18: bit 2 echoes frame one frame later
// R19: auto power code 11 acts as normal
module acpc_ctrl
	import acpc_pkg::*;
#(
	parameter int CONV_CYCLES = `ACPC_CONV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	input wire logic convert_start_pin_n,
	output logic core_power_on,
	output logic bias_power_on,
	output logic [15:0] input_enable,
	output logic reference_select,
	output logic result_valid
);
	// the burst tick counter is sixteen bits wide
	if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_conv_range
		$error("CONV_CYCLES out of range");
	end

	// ==========================================================
	// serial link, sclk domain
	// the frame is cleared by cs_n itself since sclk stands still between frames
	logic frame_rst;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [15:0] rx_sr_q, rx_sr_d;
	logic [15:0] frame_word_q, frame_word_d;
	logic frame_tgl_q, frame_tgl_d;
	logic [15:0] echo_sr_q, echo_sr_d;
	logic dout_q, dout_d;
	logic echo_en_q, echo_en_d;
	logic echo_on;

	assign frame_rst = rst | cs_n;

	// shift in msb first, hand the sixteenth bit's word across
	always_comb begin
		bit_cnt_d = bit_cnt_q + 4'h1;
		rx_sr_d = {rx_sr_q[14:0], din};
		frame_word_d = frame_word_q;
		frame_tgl_d = frame_tgl_q;
		echo_sr_d = {echo_sr_q[14:0], 1'b0};
		dout_d = echo_on & echo_sr_q[15]; // [R18]
		// echo enable is taken from the setup frame on this clock, so it stands for whole frames
		echo_en_d = echo_en_q;
		if (bit_cnt_q == 4'hf) begin
			frame_word_d = rx_sr_d;
			frame_tgl_d = ~frame_tgl_q;
			echo_sr_d = rx_sr_d; // shown during the next frame [R18]
			if (rx_sr_d[`ACPC_SEL_CODE_MSB:`ACPC_SEL_CODE_LSB] == `ACPC_SETUP_CODE) begin
				echo_en_d = rx_sr_d[`ACPC_ECHO_BIT]; // [R18]
			end
		end
	end

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_q <= 4'h0;
			rx_sr_q <= 16'h0000;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			rx_sr_q <= rx_sr_d;
		end
	end

	// these survive cs_n, so only the system reset clears them
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			frame_word_q <= 16'h0000;
			frame_tgl_q <= 1'b0;
			echo_sr_q <= 16'h0000;
			dout_q <= 1'b0;
			echo_en_q <= 1'b0;
		end else begin
			frame_word_q <= frame_word_d;
			frame_tgl_q <= frame_tgl_d;
			echo_sr_q <= echo_sr_d;
			dout_q <= dout_d;
			echo_en_q <= echo_en_d;
		end
	end
	assign echo_on = echo_en_q;
	assign dout = dout_q;

	// ==========================================================
	// synchronisers into ref_clk
	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic cv_s1_q, cv_s2_q, cv_s3_q;
	logic tg_s1_q, tg_s2_q, tg_s3_q;
	logic cs_rise, cs_fall, cnv_fall, frame_evt;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			cv_s1_q <= 1'b1;
			cv_s2_q <= 1'b1;
			cv_s3_q <= 1'b1;
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			cv_s1_q <= convert_start_pin_n;
			cv_s2_q <= cv_s1_q;
			cv_s3_q <= cv_s2_q;
			tg_s1_q <= frame_tgl_q;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
		end
	end
	assign cs_rise = cs_s2_q & ~cs_s3_q;
	assign cs_fall = ~cs_s2_q & cs_s3_q;
	assign cnv_fall = ~cv_s2_q & cv_s3_q;
	// frame_word_q is stable for sixteen sclk periods after the toggle
	assign frame_evt = tg_s2_q ^ tg_s3_q;

	// ==========================================================
	// register file and bus slave
	logic [15:0] setup_q, setup_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic software_convert_bit_q, software_convert_bit_d;
	logic armed_q, armed_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic bus_take, wr_ctrl, auto_act;
	logic [1:0] pm_field, spm_field;
	acpc_state_t state_q, state_d;
	logic [1:0] warm_q, warm_d;
	logic core_q, bias_q, valid_q;

	assign bus_take = (avs_read | avs_write) & ~wait_q;
	assign wr_ctrl = avs_write & ~wait_q & (avs_address == `ACPC_ADDR_CTRL);
	assign pm_field = {ctrl_q[`ACPC_CTRL_PM_HI], ctrl_q[`ACPC_CTRL_PM_LO]};
	assign spm_field = setup_q[`ACPC_SPM_MSB:`ACPC_SPM_LSB]; // [R17]
	// code 11 behaves as normal [R19] [R8]
	assign auto_act = (pm_field == `ACPC_PWR_FULL) | (pm_field == `ACPC_PWR_PARTIAL);

	// one wait cycle per request, then a single accepting cycle
	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		setup_d = setup_q;
		software_convert_bit_d = software_convert_bit_q;
		armed_d = armed_q & auto_act;
		if ((avs_read | avs_write) & wait_q) begin
			wait_d = 1'b0;
			case (avs_address)
				`ACPC_ADDR_CTRL: rdata_d = {24'h000000, ctrl_q[7:4], software_convert_bit_q, ctrl_q[2:0]};
				`ACPC_ADDR_SETUP: rdata_d = {16'h0000, setup_q};
				`ACPC_ADDR_STATUS: rdata_d = {26'h0000000, warm_q, valid_q, bias_q, core_q,
					state_q == ST_DOWN};
				default: rdata_d = 32'h00000000;
			endcase
		end
		// power-down is retention only; nothing here reloads on wake [R11]
		if (frame_evt && frame_word_q[`ACPC_SEL_CODE_MSB:`ACPC_SEL_CODE_LSB] == `ACPC_SETUP_CODE) begin
			setup_d = frame_word_q; // [R13]
		end
		// a pending request is used by the rise that wakes, from running or from power-down
		if (ctrl_q[`ACPC_CTRL_INTCLK] && cs_rise && state_q != ST_BURST && spm_field == `ACPC_PWR_NORMAL) begin
			software_convert_bit_d = 1'b0; // [R7]
		end
		if (wr_ctrl) begin
			ctrl_d = avs_writedata[7:0];
			ctrl_d[`ACPC_CTRL_SOFTWARE_CONVERT_BIT] = 1'b0;
			// a fresh write wins over a same-cycle consume
			if (avs_writedata[`ACPC_CTRL_SOFTWARE_CONVERT_BIT]) begin
				software_convert_bit_d = 1'b1;
			end
			armed_d = (avs_writedata[2:1] == `ACPC_PWR_FULL) | (avs_writedata[2:1] == `ACPC_PWR_PARTIAL);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
			ctrl_q <= 8'h00;
			setup_q <= `ACPC_SETUP_RESET;
			software_convert_bit_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			setup_q <= setup_d;
			software_convert_bit_q <= software_convert_bit_d;
			armed_q <= armed_d;
		end
	end
	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	// ==========================================================
	// power and conversion sequencing
	logic int_mode, static_off, wake_evt, conv_evt, burst_last;
	logic [15:0] tick_q, tick_d;
	logic [5:0] nconv_q, nconv_d;
	logic [5:0] nconv_total;
	logic core_d, bias_d, valid_d;
	logic [15:0] sel_q, sel_d;
	logic refd_q, refd_d;

	assign int_mode = ctrl_q[`ACPC_CTRL_INTCLK];
	assign static_off = spm_field != `ACPC_PWR_NORMAL; // [R2]
	assign wake_evt = ~static_off & (cnv_fall | (cs_rise & software_convert_bit_q)); // [R7]

	// averaging only counts in internal clock mode
	always_comb begin
		nconv_total = 6'd1;
		if (int_mode && setup_q[`ACPC_AVERAGING_ENABLE_BIT]) begin // [R15]
			case (setup_q[`ACPC_NAVG_MSB:`ACPC_NAVG_LSB]) // [R16]
				2'h0: nconv_total = 6'd4;
				2'h1: nconv_total = 6'd8;
				2'h2: nconv_total = 6'd16;
				default: nconv_total = 6'd32;
			endcase
		end
	end
	assign burst_last = (state_q == ST_BURST) && (tick_q == 16'(CONV_CYCLES - 1)) && (nconv_q == nconv_total - 6'd1);

	always_comb begin
		state_d = state_q;
		tick_d = tick_q;
		nconv_d = nconv_q;
		conv_evt = 1'b0;
		warm_d = warm_q;
		case (state_q)
			ST_RUN: begin
				if (int_mode && wake_evt) begin
					state_d = ST_BURST;
				end else if (!int_mode && cs_rise) begin
					conv_evt = 1'b1;
					if (auto_act && armed_q) begin
						state_d = ST_DOWN; // [R4] [R9]
					end
				end
			end
			ST_BURST: begin
				tick_d = tick_q + 16'h0001;
				if (tick_q == 16'(CONV_CYCLES - 1)) begin
					tick_d = 16'h0000;
					nconv_d = nconv_q + 6'd1;
					conv_evt = 1'b1;
				end
				if (burst_last) begin
					nconv_d = 6'd0;
					state_d = auto_act ? ST_DOWN : ST_RUN; // [R6]
				end
			end
			ST_DOWN: begin
				if (!auto_act) begin
					state_d = ST_RUN;
				end else if (!int_mode && cs_fall) begin
					state_d = ST_RUN; // [R5] [R12]
				end else if (int_mode && wake_evt) begin
					state_d = ST_BURST; // [R7]
				end
				if (state_d != ST_DOWN) begin
					warm_d = `ACPC_WARM_CONVS; // [R10]
				end
			end
			default: state_d = ST_RUN;
		endcase
		if (conv_evt && warm_q != 2'h0) begin
			warm_d = warm_q - 2'h1; // [R10]
		end
		valid_d = conv_evt && (warm_q == 2'h0); // [R10]
		// static shutdown overrides the auto power modes on core and bias [R3]
		core_d = ~static_off & (state_d != ST_DOWN); // [R9]
		bias_d = core_d | (spm_field == `ACPC_PWR_PARTIAL) |
			(~static_off & (pm_field == `ACPC_PWR_PARTIAL)); // [R3] [R12]
		sel_d = 16'h0001 << ctrl_q[`ACPC_CTRL_SEL_MSB:`ACPC_CTRL_SEL_LSB]; // [R1]
		refd_d = setup_q[`ACPC_REFERENCE_SELECT_BIT]; // [R14]
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_RUN;
			tick_q <= 16'h0000;
			nconv_q <= 6'd0;
			warm_q <= 2'h0;
			valid_q <= 1'b0;
			core_q <= 1'b1;
			bias_q <= 1'b1;
			sel_q <= 16'h0001;
			refd_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tick_q <= tick_d;
			nconv_q <= nconv_d;
			warm_q <= warm_d;
			valid_q <= valid_d;
			core_q <= core_d;
			bias_q <= bias_d;
			sel_q <= sel_d;
			refd_q <= refd_d;
		end
	end
	assign core_power_on = core_q;
	assign bias_power_on = bias_q;
	assign input_enable = sel_q;
	assign reference_select = refd_q;
	assign result_valid = valid_q;

	// ==========================================================
	// checks
	AST_SEL_DECODE: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
		input_enable == (16'h0001 << $past(ctrl_q[7:4]))) else $error("input enable mismatch");
	AST_STATIC_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
		(spm_field == 2'h1) |=> !core_power_on && !bias_power_on) else $error("static full not off");
	AST_PARTIAL_BIAS: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		(spm_field == 2'h2) |=> !core_power_on && bias_power_on) else $error("partial shutdown wrong");
	AST_EXT_DOWN: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
		(state_q == ST_RUN && !int_mode && cs_rise && auto_act && armed_q && !static_off)
		|=> ##1 !core_power_on) else $error("no power-down at frame end");
	AST_EXT_WAKE: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
		(state_q == ST_DOWN && auto_act && !int_mode && cs_fall && !static_off) |=> ##1 core_power_on)
		else $error("no wake on cs fall");
	AST_BURST_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
		(state_q == ST_BURST && !burst_last) |=> state_q == ST_BURST) else $error("left burst early");
	AST_INT_WAKE: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		(state_q == ST_DOWN && int_mode && auto_act && wake_evt) |=> state_q == ST_BURST)
		else $error("internal wake missed");
	AST_CODE11: assert property (@(posedge ref_clk) disable iff (rst) // [R19]
		(pm_field == 2'h3) |-> !auto_act) else $error("code 11 not normal");
	AST_WARM: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
		(state_q == ST_DOWN && state_d != ST_DOWN) |=> warm_q == 2'h2 ##0 !result_valid)
		else $error("warm-up not started");
	AST_SETUP_WR: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
		(frame_evt && frame_word_q[15:11] == 5'h10) |=> setup_q == $past(frame_word_q))
		else $error("setup write lost");
	AST_SETUP_KEEP: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
		!frame_evt |=> $stable(setup_q)) else $error("setup changed without frame");
	AST_REFERENCE_SELECT: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
		##1 reference_select == $past(setup_q[10])) else $error("reference select mismatch");
	AST_AVG_EXT: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
		!int_mode |-> nconv_total == 6'd1) else $error("averaging outside internal mode");
	AST_AVG_CNT: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
		(int_mode && setup_q[9] && setup_q[8:7] == 2'h1) |-> nconv_total == 6'd8) else $error("avg count");
	AST_SOFTWARE_CONVERT_BIT_USED: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		(state_q == ST_DOWN && int_mode && cs_rise && software_convert_bit_q && !static_off && !wr_ctrl) |=> !software_convert_bit_q)
		else $error("software convert not consumed");
endmodule // acpc_ctrl

// file: acpc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host serial master: 6 ns link clock, only inside frames
module acpc_host_model
	import acpc_pkg::*;
(
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	// link idles low with chip select released
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// one 16-bit word, msb first; echo bits are taken after each fall
	// the phase offset keeps the link unrelated to the system clock
	task automatic send(input logic [15:0] w, output logic [15:0] echo);
		int i;
		#1.7 cs_n = 1'b0;
		for (i = 15; i >= 0; i--) begin
			din = w[i]; // host supplies the register code in bits 15:11
			#3 sclk = 1'b1;
			#3 sclk = 1'b0;
			echo[i] = dout;
		end
		#3 cs_n = 1'b1; // rising chip select ends the frame; it wakes the core only with a software convert pending
		din = ~din; // released line: show the inverse, not the last bit
		#50;
	endtask

	// bare chip-select edges with the clock standing still
	task automatic select();
		#1.7 cs_n = 1'b0;
	endtask

	task automatic deselect();
		#1.7 cs_n = 1'b1;
	endtask
endmodule // acpc_host_model

// file: tb_top.sv
`timescale 1ns/1ps
`include "acpc_defs.svh"
module tb_top
	import acpc_pkg::*;
;
	localparam int CONV = 4;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, sclk, cs_n, din, dout;
	logic convert_start_pin_n, core_power_on, bias_power_on, reference_select, result_valid;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] input_enable, echo;
	logic [7:0] row_ctrl [16];
	logic [15:0] row_en [16];
	int mismatches = 0;
	int total_checks = 0;
	int pulses = 0;
	int base = 0;
	int i;

	// ==========================================================
	// clock, design, host
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	acpc_ctrl #(.CONV_CYCLES(CONV)) u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(dout), .convert_start_pin_n(convert_start_pin_n),
		.core_power_on(core_power_on), .bias_power_on(bias_power_on), .input_enable(input_enable),
		.reference_select(reference_select), .result_valid(result_valid));

	acpc_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

	// count valid results; the host ignores the warm-up ones by counting only pulses
	always @(posedge ref_clk) begin
		if (result_valid === 1'b1)
			pulses <= pulses + 1;
	end

	// ==========================================================
	// helpers
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// one Avalon cycle held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		avs_address <= addr;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			$display("unexpected bus answer: none within 50 cycles");
		end
	endtask

	// setup word lands a few cycles after the frame; 12 leaves margin
	task automatic frame(input logic [15:0] w);
		u_host.send(w, echo);
		repeat (12) @(posedge ref_clk);
	endtask

	task automatic wait_core(input logic v);
		int n;
		n = 0;
		while (core_power_on !== v && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task automatic start_pulse();
		@(posedge ref_clk);
		convert_start_pin_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		convert_start_pin_n <= 1'b1;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog: the sequence needs well under 10000 cycles
	initial begin
		#300000;
		mismatches++;
		wrap_up();
	end

	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		convert_start_pin_n = 1'b1;
		for (i = 0; i < 16; i++) begin
			row_ctrl[i] = 8'(i << 4);
			row_en[i] = 16'h0001 << i;
		end
		repeat (6) @(posedge ref_clk);
		check("core in reset", 32'(core_power_on), 32'h1);
		check("bias in reset", 32'(bias_power_on), 32'h1);
		check("reference in reset", 32'(reference_select), 32'h0);
		check("enable in reset", 32'(input_enable), 32'h1);
		rst <= 1'b0;
		// rows: every select code against its one-hot enable
		for (i = 0; i < 16; i++) begin
			bus(1'b1, `ACPC_ADDR_CTRL, 32'(row_ctrl[i]));
			repeat (2) @(posedge ref_clk);
			check("input_enable", 32'(input_enable), 32'(row_en[i]));
			bus(1'b0, `ACPC_ADDR_CTRL, 32'h0);
			check("ctrl readback", 32'(rd[7:0]), 32'(row_ctrl[i]));
		end
		bus(1'b1, 4'hc, 32'hffff_ffff);
		bus(1'b0, 4'hc, 32'h0);
		check("unmapped read", rd, 32'h0);
		frame(16'h8400);
		check("reference", 32'(reference_select), 32'h1);
		frame(16'h9800); // other register code must not land
		bus(1'b0, `ACPC_ADDR_SETUP, 32'h0);
		check("setup", 32'(rd[15:0]), 32'h8400);
		frame(16'h8404);
		frame(16'h1234);
		check("echo on", 32'(echo), 32'h8404);
		frame(16'h8400);
		frame(16'h1234);
		check("echo off", 32'(echo), 32'h0);
		// static field codes 1,2,3 then back to normal
		for (i = 1; i < 5; i++) begin
			frame(16'h8400 | 16'((i % 4) << 3));
			wait_core(i == 4);
			check("static core", 32'(core_power_on), 32'(i == 4));
			check("static bias", 32'(bias_power_on), 32'((i % 2) == 0));
		end
		// external clock: auto codes 01, 10, 11
		for (i = 1; i < 4; i++) begin
			bus(1'b1, `ACPC_ADDR_CTRL, 32'(i << 1));
			frame(16'h1234);
			wait_core(i == 3);
			check("auto core", 32'(core_power_on), 32'(i == 3));
			check("auto bias", 32'(bias_power_on), 32'(i != 1));
			bus(1'b0, `ACPC_ADDR_SETUP, 32'h0);
			check("setup kept", 32'(rd[15:0]), 32'h8400);
			u_host.select();
			wait_core(1'b1);
			check("wake on select", 32'(core_power_on), 32'h1);
			u_host.deselect();
			repeat (12) @(posedge ref_clk);
		end
		bus(1'b1, `ACPC_ADDR_CTRL, 32'h0);
		frame(16'h1234);
		check("normal core", 32'(core_power_on), 32'h1);
		// internal clock, averaging of 4 then 8
		frame(16'h8600);
		bus(1'b1, `ACPC_ADDR_CTRL, 32'h3);
		start_pulse();
		wait_core(1'b0);
		// let the last pulse of the burst be counted before taking the base
		@(posedge ref_clk);
		base = pulses;
		start_pulse();
		repeat (80) @(posedge ref_clk);
		check("results of 4", 32'(pulses - base), 32'h2);
		check("down after burst", 32'(core_power_on), 32'h0);
		frame(16'h8680);
		base = pulses;
		bus(1'b1, `ACPC_ADDR_CTRL, 32'hb);
		frame(16'h1234);
		repeat (80) @(posedge ref_clk);
		check("results of 8", 32'(pulses - base), 32'h6);
		check("down after software_convert_bit", 32'(core_power_on), 32'h0);
		// mid-run reset: outputs and setup go back to their reset values
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("core after reset", 32'(core_power_on), 32'h1);
		check("enable after reset", 32'(input_enable), 32'h1);
		check("valid after reset", 32'(result_valid), 32'h0);
		rst <= 1'b0;
		bus(1'b0, `ACPC_ADDR_SETUP, 32'h0);
		check("setup after reset", 32'(rd[15:0]), 32'(`ACPC_SETUP_RESET));
		bus(1'b0, `ACPC_ADDR_STATUS, 32'h0);
		check("status after reset", 32'(rd[5:0]), 32'h6);
		wrap_up();
	end
endmodule // tb_top
